// File: pkg/eip_pkg.sv
package eip_pkg;
  // ****************************************
  // vector types
  // ****************************************
  localparam int EIP_NUM_IRQ = 5;
  localparam logic [7:0] EIP_TYPE_NMI = 8'h02;
  localparam logic [7:0] EIP_TYPE_IRQ0 = 8'h0c;
  localparam logic [7:0] EIP_TYPE_IRQ1 = 8'h0d;
  localparam logic [7:0] EIP_TYPE_IRQ2 = 8'h0e;
  localparam logic [7:0] EIP_TYPE_IRQ3 = 8'h0f;
  localparam logic [7:0] EIP_TYPE_IRQ4 = 8'h11;
  // ****************************************
  // reset values and timing
  // ****************************************
  localparam logic [4:0] EIP_MASK_RST = 5'h1f;
  localparam int EIP_ACK_CYCLES = 2;
  // two synchroniser stages plus the registered pin enable
  localparam int EIP_SETTLE_CYCLES = 3;
  typedef enum logic [2:0] {
    EIP_IDLE = 3'b001,
    EIP_ACK = 3'b010,
    EIP_WAIT = 3'b100
  } eip_state_t;
endpackage : eip_pkg

// File: design/eip_sync.sv
`timescale 1ns/10ps
module eip_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
  assign sync_out = sync_q;
endmodule : eip_sync

// File: design/eip_top.sv
// What this block does
// - five external requests, active high, maskable, each diverts program flow.
// - input zero vectors to type 12, input one to type 13.
// - inputs two, three, four vector to 14, 15, 17; 16 unused.
// - inputs zero and one pair with acknowledge lines for cascade expansion.
// - acknowledge zero, active low, answers input zero; requester waits for it.
// - acknowledge one, active low, answers input one; shares pin with input three.
// - nmi assertion latched internally, serviced as type 2 regardless of masks.
`timescale 1ns/10ps
module eip_top
  import eip_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ext_irq_zero,
  input wire logic ext_irq_one,
  input wire logic ext_irq_two_in,
  input wire logic ext_irq_three_in,
  input wire logic ext_irq_four,
  input wire logic nmi,
  input wire logic cascade_en,
  input wire logic [4:0] irq_mask,
  input wire logic intr_ack,
  output logic irq_ack_zero_low,
  output logic irq_ack_zero_oe,
  output logic irq_ack_one_low,
  output logic irq_ack_one_oe,
  output logic intr_req,
  output logic [7:0] intr_type,
  output logic [4:0] irq_pending
);
  // ****************************************
  // input synchronisers
  // ****************************************
  logic [5:0] raw_s;
  logic [5:0] pin_s;

  // nmi rides the same two stages, so every pin sees one delay
  assign raw_s = {nmi, ext_irq_four, ext_irq_three_in, ext_irq_two_in, ext_irq_one, ext_irq_zero};
  eip_sync #(.WIDTH(6)) u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .async_in(raw_s),
    .sync_out(pin_s)
  );

  // ****************************************
  // request capture
  // ****************************************
  eip_state_t state_q, state_d;
  logic [4:0] req_lvl;
  logic [4:0] svc_sel;
  logic nmi_prev_q, nmi_prev_d;
  logic nmi_lat_q, nmi_lat_d;
  logic take;
  logic [EIP_SETTLE_CYCLES-1:0] casc_hist_q, casc_hist_d;
  logic shared_off;

  // the shared pins still read the driven ack level until the synchroniser drains
  always_comb begin
    casc_hist_d = {casc_hist_q[EIP_SETTLE_CYCLES-2:0], cascade_en};
    shared_off = cascade_en || (|casc_hist_q);
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      casc_hist_q <= '0;
    end else begin
      casc_hist_q <= casc_hist_d;
    end
  end

  // in cascade mode the shared pins carry acknowledges, so their requests are ignored
  always_comb begin
    req_lvl = pin_s[4:0] & ~irq_mask;
    if (shared_off) begin
      req_lvl[2] = 1'b0;
      req_lvl[3] = 1'b0;
    end
  end

  // fixed priority, lowest input wins
  always_comb begin
    svc_sel = '0;
    for (int i = EIP_NUM_IRQ - 1; i >= 0; i--) begin
      if (req_lvl[i]) begin
        svc_sel = '0;
        svc_sel[i] = 1'b1;
      end
    end
  end

  // edge caught so a short pulse is not lost; set wins over the service clear
  assign take = (state_q == EIP_IDLE) && intr_ack && intr_req;

  always_comb begin
    nmi_prev_d = pin_s[5];
    nmi_lat_d = nmi_lat_q;
    if (take && nmi_lat_q) begin
      nmi_lat_d = 1'b0;
    end
    if (pin_s[5] && !nmi_prev_q) begin
      nmi_lat_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      nmi_prev_q <= 1'b0;
      nmi_lat_q <= 1'b0;
    end else begin
      nmi_prev_q <= nmi_prev_d;
      nmi_lat_q <= nmi_lat_d;
    end
  end

  // ****************************************
  // service sequencer
  // ****************************************
  logic [7:0] type_q, type_d;
  logic req_q, req_d;
  logic ack0_q, ack0_d;
  logic ack1_q, ack1_d;
  logic [1:0] cnt_q, cnt_d;
  logic [4:0] pend_q, pend_d;

  always_comb begin
    pend_d = req_lvl;
    state_d = state_q;
    type_d = type_q;
    req_d = 1'b0;
    ack0_d = 1'b1;
    ack1_d = 1'b1;
    cnt_d = cnt_q;
    case (state_q)
      EIP_IDLE: begin
        if (nmi_lat_d) begin
          type_d = EIP_TYPE_NMI;
          req_d = 1'b1;
        end else begin
          req_d = |req_lvl;
          if (svc_sel[0]) type_d = EIP_TYPE_IRQ0;
          else if (svc_sel[1]) type_d = EIP_TYPE_IRQ1;
          else if (svc_sel[2]) type_d = EIP_TYPE_IRQ2;
          else if (svc_sel[3]) type_d = EIP_TYPE_IRQ3;
          else if (svc_sel[4]) type_d = EIP_TYPE_IRQ4;
        end
        if (take) begin
          req_d = 1'b0;
          // the ack follows the vector just handed over, not the next pick
          if (cascade_en && (type_q == EIP_TYPE_IRQ0 || type_q == EIP_TYPE_IRQ1)) begin
            state_d = EIP_ACK;
            cnt_d = 2'(EIP_ACK_CYCLES - 1);
            ack0_d = (type_q != EIP_TYPE_IRQ0);
            ack1_d = (type_q != EIP_TYPE_IRQ1);
          end else begin
            state_d = EIP_WAIT;
          end
        end
      end
      EIP_ACK: begin
        ack0_d = ack0_q;
        ack1_d = ack1_q;
        if (cnt_q == 2'h0) begin
          ack0_d = 1'b1;
          ack1_d = 1'b1;
          state_d = EIP_WAIT;
        end else begin
          cnt_d = cnt_q - 2'h1;
        end
      end
      EIP_WAIT: begin
        // waiting here until intr_ack drops lets a served level drop before it is sampled again
        if (!intr_ack) state_d = EIP_IDLE;
      end
      default: state_d = EIP_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_q <= EIP_IDLE;
      type_q <= 8'h00;
      req_q <= 1'b0;
      ack0_q <= 1'b1;
      ack1_q <= 1'b1;
      cnt_q <= 2'h0;
      pend_q <= 5'h00;
    end else begin
      state_q <= state_d;
      type_q <= type_d;
      req_q <= req_d;
      ack0_q <= ack0_d;
      ack1_q <= ack1_d;
      cnt_q <= cnt_d;
      pend_q <= pend_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  logic oe_q, oe_d;

  // the pins turn around one cycle after the mode bit, like every other output
  always_comb begin
    oe_d = cascade_en;
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= oe_d;
    end
  end

  assign intr_req = req_q;
  assign intr_type = type_q;

  assign irq_ack_zero_low = ack0_q;
  assign irq_ack_one_low = ack1_q;
  assign irq_ack_zero_oe = oe_q;
  assign irq_ack_one_oe = oe_q;
  assign irq_pending = pend_q;
endmodule : eip_top

// File: tb/eip_sva.sv
`timescale 1ns/10ps
module eip_sva (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic nmi,
  input wire logic cascade_en,
  input wire logic [4:0] irq_mask,
  input wire logic intr_ack,
  input wire logic irq_ack_zero_low,
  input wire logic irq_ack_zero_oe,
  input wire logic irq_ack_one_low,
  input wire logic irq_ack_one_oe,
  input wire logic intr_req,
  input wire logic [7:0] intr_type,
  input wire logic [4:0] irq_pending
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  take_drop_a:
    assert property (intr_req && intr_ack |=> !intr_req) else $error("req kept");
  type_set_a:
    assert property (intr_req |-> intr_type inside {8'h02, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h11}) else $error("type");
  ack_zero_a:
    assert property (intr_req && intr_ack && cascade_en && intr_type == 8'h0c
      |=> !irq_ack_zero_low [*2] ##1 irq_ack_zero_low) else $error("ack zero");
  ack_one_a:
    assert property (intr_req && intr_ack && cascade_en && intr_type == 8'h0d
      |=> !irq_ack_one_low [*2] ##1 irq_ack_one_low) else $error("ack one");
  pin_dir_a:
    assert property ($past(resetn) |-> irq_ack_zero_oe == $past(cascade_en) && irq_ack_one_oe == $past(cascade_en))
      else $error("oe");
  casc_ign_a:
    assert property ($past(cascade_en) && $past(cascade_en, 2) |-> irq_pending[3:2] == 2'h0) else $error("shared");
  mask_hold_a:
    assert property ($past(resetn) |-> (irq_pending & $past(irq_mask)) == 5'h00) else $error("mask");
  nmi_svc_a:
    assert property ($rose(nmi) && !intr_req && !intr_ack |-> ##[1:8] intr_req && intr_type == 8'h02)
      else $error("nmi");
  casc_drain_a:
    assert property ($past(resetn, 2) && $past(resetn, 3) && $past(resetn, 4) && $past(cascade_en, 4)
      |-> irq_pending[3:2] == 2'h0) else $error("drain");
endmodule : eip_sva

// File: tb/eip_peer.sv
`timescale 1ns/10ps
module eip_peer (
  input wire logic clk_sys,
  input wire logic [1:0] go,
  input wire logic irq_ack_zero_low,
  input wire logic irq_ack_one_low,
  output logic [1:0] req
);
  // holds its request until acked, as a cascaded controller must
  initial req = 2'h0;
  always @(posedge clk_sys) begin
    req <= (req | go) & {irq_ack_one_low, irq_ack_zero_low};
  end
endmodule : eip_peer

// File: tb/eip_top_test.sv
`timescale 1ns/10ps
module eip_top_test;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic nmi = 1'b0;
  logic cascade_en = 1'b0;
  logic intr_ack = 1'b0;
  logic [4:0] irq_mask = 5'h00;
  logic [4:0] pin = 5'h00;
  logic [1:0] go = 2'h0;
  logic [1:0] preq;
  logic a0_n, a0_oe, a1_n, a1_oe, intr_req;
  logic [7:0] intr_type;
  logic [4:0] irq_pending;
  int error_cnt = 0;
  int n_checks = 0;
  initial forever #10 clk_sys = ~clk_sys;
  eip_peer peer (.clk_sys(clk_sys), .go(go), .irq_ack_zero_low(a0_n), .irq_ack_one_low(a1_n), .req(preq));
  // shared pins carry the device's ack while it drives them
  eip_top uut (.clk_sys(clk_sys), .resetn(resetn), .ext_irq_zero(pin[0] | preq[0]), .ext_irq_one(pin[1] | preq[1]),
    .ext_irq_two_in(a0_oe ? a0_n : pin[2]), .ext_irq_three_in(a1_oe ? a1_n : pin[3]), .ext_irq_four(pin[4]),
    .nmi(nmi), .cascade_en(cascade_en), .irq_mask(irq_mask), .intr_ack(intr_ack), .irq_ack_zero_low(a0_n),
    .irq_ack_zero_oe(a0_oe), .irq_ack_one_low(a1_n), .irq_ack_one_oe(a1_oe), .intr_req(intr_req),
    .intr_type(intr_type), .irq_pending(irq_pending));
  task automatic chk(input logic ok);
    n_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] %0t mismatch", $time);
    end
  endtask : chk
  task automatic svc(input logic [7:0] t, input logic [1:0] a);
    for (int k = 0; k < 20 && intr_req !== 1'b1; k++) @(posedge clk_sys);
    chk(intr_type === t);
    intr_ack <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk(intr_req === 1'b0 && {a1_n, a0_n} === a);
    pin <= 5'h00;
    nmi <= 1'b0;
    repeat (6) @(posedge clk_sys);
    intr_ack <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : svc
  task automatic t_plain();
    logic [7:0] ty [5] = '{8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h11};
    for (int i = 0; i < 5; i++) begin
      irq_mask <= 5'h1f;
      pin <= 5'h01 << i;
      repeat (6) @(posedge clk_sys);
      chk(intr_req === 1'b0 && irq_pending === 5'h00);
      irq_mask <= 5'h00;
      svc(ty[i], 2'b11);
    end
  endtask : t_plain
  task automatic t_casc();
    cascade_en <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk({a1_oe, a0_oe} === 2'b11 && irq_pending === 5'h00);
    go <= 2'h1;
    @(posedge clk_sys);
    go <= 2'h0;
    svc(8'h0c, 2'b10);
    go <= 2'h2;
    @(posedge clk_sys);
    go <= 2'h0;
    svc(8'h0d, 2'b01);
    chk(irq_pending === 5'h00 && preq === 2'h0);
    cascade_en <= 1'b0;
    // the shared pins still read high for a few cycles, so no request may slip out
    repeat (6) begin
      @(posedge clk_sys);
      chk(intr_req === 1'b0 && irq_pending === 5'h00);
    end
    chk({a1_oe, a0_oe} === 2'b00);
  endtask : t_casc
  task automatic t_nmi();
    irq_mask <= 5'h1f;
    nmi <= 1'b1;
    svc(8'h02, 2'b11);
  endtask : t_nmi
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk(intr_req === 1'b0 && intr_type === 8'h00 && irq_pending === 5'h00);
    chk({a1_n, a0_n} === 2'b11 && {a1_oe, a0_oe} === 2'b00);
    t_plain();
    t_casc();
    t_nmi();
    final_report();
  end
  initial begin
    repeat (3000) @(posedge clk_sys);
    error_cnt++;
    final_report();
  end
endmodule : eip_top_test
bind eip_top eip_sva chk_i (.*);
